//--- design/was_pkg.sv
// package: constants and types for the waveform acquisition store
package was_pkg;
  localparam int unsigned SMP_W       = 16;
  localparam int unsigned ACC_W       = 24;
  localparam int unsigned HIST_DEPTH  = 1000;          // most records sequential store can hold
  localparam int unsigned HIST_AW     = 10;
  localparam int unsigned STAMP_W     = 32;
  localparam int unsigned MAP_PAGE    = 100;           // records listed per map page
  localparam logic [9:0]  SEQ_MIN     = 10'd2;
  localparam logic [9:0]  SEQ_MAX     = 10'd1000;
  localparam logic [9:0]  SEQ_INF     = 10'd0;         // count 0 stands for unbounded
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SRATE_MHZ   = 10;            // input sample rate 10 MS/s
  localparam int unsigned SAMPLE_DIV  = CLK_MHZ / SRATE_MHZ;
  localparam int unsigned BOX_MAXLOG  = 8;             // 256-sample window at most
  localparam logic [7:0]  STAMP_SUBSEC_MASK = 8'h00;   // sub-second digits of loaded records

  // register byte offsets
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_RATE   = 6'h04;
  localparam logic [5:0] REG_SEQCNT = 6'h08;
  localparam logic [5:0] REG_SEL    = 6'h0C;
  localparam logic [5:0] REG_RANGE  = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h14;
  localparam logic [5:0] REG_STAMP  = 6'h18;
  localparam logic [5:0] REG_MAP    = 6'h1C;
  localparam logic [5:0] REG_LOAD   = 6'h20;
  localparam logic [5:0] REG_TIME   = 6'h24;

  // ctrl bits
  localparam int unsigned CB_RUN     = 0;
  localparam int unsigned CB_SEQ     = 1;
  localparam int unsigned CB_MAVG    = 2;
  localparam int unsigned CB_ROLL    = 3;
  localparam int unsigned CB_AVG     = 4;
  localparam int unsigned CB_ACCUM   = 5;
  localparam int unsigned CB_RECALL  = 6;
  localparam int unsigned CB_ALL     = 7;
  localparam int unsigned CB_CHANGED = 8;

  // output rate codes
  typedef enum logic [3:0] {
    RATE_10M = 4'h0, RATE_5M = 4'h1, RATE_2M = 4'h2, RATE_1M = 4'h3,
    RATE_500K = 4'h4, RATE_200K = 4'h5, RATE_100K = 4'h6, RATE_50K = 4'h7,
    RATE_20K = 4'h8, RATE_10K = 4'h9, RATE_5K = 4'hA, RATE_1K = 4'hB
  } was_rate_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100
  } was_state_t;
endpackage

//--- design/was_box_avg.sv
// file: moving average over the leading window of each decimation period
`timescale 1ns/1ps
`default_nettype none
module was_box_avg (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       smp_en,
  input  wire logic [was_pkg::SMP_W-1:0]  smp_in,
  input  wire logic                       mavg_on,
  input  wire logic [13:0]                period,
  input  wire logic [3:0]                 win_log,
  output logic                            pt_valid,
  output logic [was_pkg::SMP_W-1:0]       pt_data
);
  import was_pkg::*;
  logic [13:0]      pcnt_r, pcnt_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic             v_r, v_nxt;
  logic [SMP_W-1:0] d_r, d_nxt;
  logic [13:0]      win;
  logic [ACC_W-1:0] sum;

  assign win = 14'd1 << win_log;

  // period counter, accumulator and output point
  always_comb begin
    pcnt_nxt = pcnt_r;
    acc_nxt  = acc_r;
    v_nxt    = 1'b0;
    d_nxt    = d_r;
    sum      = acc_r + ACC_W'(smp_in);
    if (smp_en) begin
      pcnt_nxt = (pcnt_r + 14'd1 >= period) ? 14'd0 : pcnt_r + 14'd1;
      if (!mavg_on) begin
        if (pcnt_r == 14'd0) begin   // decimation keeps one sample per period
          v_nxt = 1'b1;
          d_nxt = smp_in;
        end
      end else if (pcnt_r == 14'd0) begin
        acc_nxt = ACC_W'(smp_in);      // restart with first sample at period start
        if (win == 14'd1) begin
          v_nxt = 1'b1;
          d_nxt = smp_in;
        end
      end else if (pcnt_r < win) begin
        acc_nxt = sum;                 // sum first window samples
        if (pcnt_r == win - 14'd1) begin
          v_nxt = 1'b1;
          d_nxt = SMP_W'(sum >> win_log); // divide by power-of-two window
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pcnt_r <= 14'h0000;
      acc_r  <= '0;
      v_r    <= 1'b0;
      d_r    <= '0;
    end else begin
      pcnt_r <= pcnt_nxt;
      acc_r  <= acc_nxt;
      v_r    <= v_nxt;
      d_r    <= d_nxt;
    end
  end

  assign pt_valid = v_r;
  assign pt_data  = d_r;

  a_avg_window: assert property (@(posedge ref_clk) disable iff (rst)
    (smp_en && mavg_on && pcnt_r == 14'd0) |=> (acc_r == ACC_W'($past(smp_in))))
    else $error("accumulator not restarted at period start");
endmodule
`default_nettype wire

//--- design/was_ring.sv
// file: history time-stamp ring in flip-flops
`timescale 1ns/1ps
`default_nettype none
module was_ring (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         wr_en,
  input  wire logic [was_pkg::HIST_AW-1:0]  wr_idx,
  input  wire logic [was_pkg::STAMP_W-1:0]  wr_data,
  input  wire logic [was_pkg::HIST_AW-1:0]  rd_idx,
  output logic [was_pkg::STAMP_W-1:0]       rd_data
);
  import was_pkg::*;
  logic [STAMP_W-1:0] mem_r [HIST_DEPTH];
  logic [STAMP_W-1:0] q_r, q_nxt;

  // registered read
  always_comb begin
    q_nxt = (rd_idx < HIST_AW'(HIST_DEPTH)) ? mem_r[rd_idx] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
    if (wr_en && wr_idx < HIST_AW'(HIST_DEPTH)) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  assign rd_data = q_r;
endmodule
`default_nettype wire

//--- design/was_top.sv
// file: acquisition store control, sequential store, box average and history
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module was_top (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [was_pkg::SMP_W-1:0]   smp_in,
  input  wire logic                        trig_in,
  input  wire logic                        rec_end,
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             mem_wr,
  output logic [was_pkg::SMP_W-1:0]        mem_data,
  output logic [was_pkg::HIST_AW-1:0]      rec_slot,
  output logic [was_pkg::HIST_AW-1:0]      sel_slot,
  output logic                             roll_en,
  output logic                             highlight_hit
);
  import was_pkg::*;

  // pin synchronisers for trigger and record-complete
  logic [1:0] trg_s_r, end_s_r, trg_s_nxt, end_s_nxt;
  logic       trg_q_r, trg_q_nxt;
  logic       trg_p;
  always_comb begin
    trg_s_nxt = {trg_s_r[0], trig_in};
    end_s_nxt = {end_s_r[0], rec_end};
    trg_q_nxt = trg_s_r[1];
    trg_p     = trg_s_r[1] & ~trg_q_r;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trg_s_r <= 2'b00;
      end_s_r <= 2'b00;
      trg_q_r <= 1'b0;
    end else begin
      trg_s_r <= trg_s_nxt;
      end_s_r <= end_s_nxt;
      trg_q_r <= trg_q_nxt;
    end
  end

  // sample enable divider, 10 MS/s from ref_clk
  logic [3:0] div_r, div_nxt;
  logic       smp_en;
  always_comb begin
    div_nxt = (div_r == 4'(SAMPLE_DIV - 1)) ? 4'h0 : div_r + 4'h1;
    smp_en  = (div_r == 4'h0);
  end
  always_ff @(posedge ref_clk) begin
    if (rst) div_r <= 4'h0;
    else div_r <= div_nxt;
  end

  // control registers
  logic [8:0]         ctrl_r, ctrl_nxt;
  logic [3:0]         rate_r, rate_nxt;
  logic [13:0]        ext_per_r, ext_per_nxt;
  logic [9:0]         seqcnt_r, seqcnt_nxt;
  logic [HIST_AW-1:0] sel_r, sel_nxt, start_r, start_nxt, end_r, end_nxt;
  logic [HIST_AW-1:0] map_r, map_nxt;
  logic [STAMP_W-1:0] time_r, time_nxt;
  logic [HIST_AW-1:0] wp_r, wp_nxt, fill_r, fill_nxt, taken_r, taken_nxt;
  logic               inrec_r, inrec_nxt, dirty_r, dirty_nxt;
  was_state_t         st_r, st_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic               ack_r, ack_nxt;
  logic               running, recall_ok, commit, load_wr;
  logic [STAMP_W-1:0] stamp_wr;
  logic [STAMP_W-1:0] stamp_rd;
  logic [HIST_AW-1:0] rd_idx;
  logic [13:0]        period;
  logic [3:0]         win_log;
  logic               pt_valid;
  logic [SMP_W-1:0]   pt_data;
  logic               wr_hit, cnt_ok;

  assign running   = (st_r == ST_RUN);
  assign recall_ok = ~avs_writedata[CB_AVG] & ~avs_writedata[CB_ACCUM];
  assign wr_hit    = avs_write & ~ack_r;
  assign cnt_ok    = (avs_writedata[31:10] == 22'h0) &&
                     ((avs_writedata[9:0] == SEQ_INF) ||
                      (avs_writedata[9:0] >= SEQ_MIN && avs_writedata[9:0] <= SEQ_MAX));

  // rate decode to period and power-of-two window
  always_comb begin
    period  = 14'd1;
    win_log = 4'd0;
    case (rate_r)
      RATE_10M: begin
        period  = 14'd1;
        win_log = 4'd0;
      end
      RATE_5M: begin
        period  = 14'd2;
        win_log = 4'd1;
      end
      RATE_2M: begin
        period  = 14'd5;
        win_log = 4'd2;
      end
      RATE_1M: begin
        period  = 14'd10;
        win_log = 4'd3;
      end
      RATE_500K: begin
        period  = 14'd20;
        win_log = 4'd4;
      end
      RATE_200K: begin
        period  = 14'd50;
        win_log = 4'd5;
      end
      RATE_100K: begin
        period  = 14'd100;
        win_log = 4'd6;
      end
      RATE_50K: begin
        period  = 14'd200;
        win_log = 4'd7;
      end
      default:   begin
        period  = (rate_r == RATE_20K) ? 14'd500 : ext_per_r;
        win_log = 4'(BOX_MAXLOG);
      end
    endcase
  end

  was_box_avg u_box (
    .ref_clk  (ref_clk),
    .rst      (rst | ~running),   // a restart begins a fresh decimation period
    .smp_en   (smp_en & running),
    .smp_in   (smp_in),
    .mavg_on  (ctrl_r[CB_MAVG]),
    .period   (period),
    .win_log  (win_log),
    .pt_valid (pt_valid),
    .pt_data  (pt_data)
  );

  // record completion commits only a fully read record
  assign commit   = running & inrec_r & end_s_r[1];
  assign load_wr  = wr_hit & (avs_address == REG_LOAD) & ~running;
  assign stamp_wr = load_wr ? {avs_writedata[31:8], STAMP_SUBSEC_MASK}
                            : time_r;
  // relative index resolved against write pointer
  assign rd_idx   = (wp_r >= sel_r + HIST_AW'(1)) ? wp_r - sel_r - HIST_AW'(1)
                    : HIST_AW'(HIST_DEPTH) + wp_r - sel_r - HIST_AW'(1);

  was_ring u_ring (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (commit | load_wr),
    .wr_idx  (wp_r),
    .wr_data (stamp_wr),
    .rd_idx  (rd_idx),
    .rd_data (stamp_rd)
  );

  // acquisition state, history pointer and bus registers
  always_comb begin
    ctrl_nxt    = ctrl_r;
    rate_nxt    = rate_r;
    ext_per_nxt = ext_per_r;
    seqcnt_nxt  = seqcnt_r;
    sel_nxt     = sel_r;
    start_nxt   = start_r;
    end_nxt     = end_r;
    map_nxt     = map_r;
    time_nxt    = time_r + 32'h1;
    wp_nxt      = wp_r;
    fill_nxt    = fill_r;
    taken_nxt   = taken_r;
    inrec_nxt   = inrec_r;
    dirty_nxt   = dirty_r;
    st_nxt      = st_r;
    rdata_nxt   = 32'h0;
    ack_nxt     = (avs_read | avs_write) & ~ack_r;
    if (trg_p && running) inrec_nxt = 1'b1;
    if (commit) begin
      inrec_nxt = 1'b0;
      wp_nxt    = (wp_r == HIST_AW'(HIST_DEPTH - 1)) ? '0 : wp_r + HIST_AW'(1);
      if (fill_r != HIST_AW'(HIST_DEPTH)) fill_nxt = fill_r + HIST_AW'(1);
      taken_nxt = taken_r + HIST_AW'(1);
      if (ctrl_r[CB_SEQ] && seqcnt_r != SEQ_INF &&
          taken_r + HIST_AW'(1) >= HIST_AW'(seqcnt_r)) st_nxt = ST_DONE;
    end
    if (wr_hit) begin
      case (avs_address)
        REG_CTRL: begin
          ctrl_nxt = avs_writedata[8:0];
          if (avs_writedata[CB_SEQ]) ctrl_nxt[CB_ROLL] = 1'b0;
          if (avs_writedata[CB_CHANGED]) dirty_nxt = 1'b1;
          if (avs_writedata[CB_RECALL] && recall_ok) st_nxt = ST_IDLE;
          if (avs_writedata[CB_RECALL] && !recall_ok) ctrl_nxt[CB_RECALL] = 1'b0;
          if (!avs_writedata[CB_RUN] && running) begin
            st_nxt = ST_IDLE;
            inrec_nxt = 1'b0;
          end
          if (avs_writedata[CB_RUN] && !running && !(avs_writedata[CB_RECALL] && recall_ok)) begin
            st_nxt = ST_RUN;
            taken_nxt = '0;
            if (dirty_r || avs_writedata[CB_CHANGED]) begin
              wp_nxt = '0;
              fill_nxt = '0;
              dirty_nxt = 1'b0;
            end
          end
        end
        REG_RATE: begin
          rate_nxt = avs_writedata[3:0];
          ext_per_nxt = (avs_writedata[29:16] < 14'd256) ? 14'd256 : avs_writedata[29:16];
          dirty_nxt = 1'b1;
        end
        REG_SEQCNT: if (cnt_ok) begin
          seqcnt_nxt = avs_writedata[9:0];
          dirty_nxt = 1'b1;
        end
        REG_SEL: if (!running && fill_r != '0 &&
                     avs_writedata[HIST_AW-1:0] < fill_r &&
                     (!ctrl_r[CB_ALL] || (avs_writedata[HIST_AW-1:0] >= start_r &&
                                          avs_writedata[HIST_AW-1:0] <= end_r)))
                   sel_nxt = avs_writedata[HIST_AW-1:0];
        REG_RANGE: if (!running &&
                       avs_writedata[HIST_AW-1:0] <= sel_r &&
                       avs_writedata[16+HIST_AW-1:16] >= sel_r &&
                       avs_writedata[16+HIST_AW-1:16] < fill_r) begin
          start_nxt = avs_writedata[HIST_AW-1:0];
          end_nxt   = avs_writedata[16+HIST_AW-1:16];
        end
        REG_MAP: if (!running && avs_writedata[HIST_AW-1:0] * MAP_PAGE < HIST_DEPTH)
                   map_nxt = avs_writedata[HIST_AW-1:0];
        REG_TIME: time_nxt = avs_writedata;
        REG_LOAD: if (!running) begin
          wp_nxt = (wp_r == HIST_AW'(HIST_DEPTH - 1)) ? '0 : wp_r + HIST_AW'(1);
          if (fill_r != HIST_AW'(HIST_DEPTH)) fill_nxt = fill_r + HIST_AW'(1);
          sel_nxt = '0;
        end
        default: ;
      endcase
    end
    if (avs_read && !ack_r) begin
      case (avs_address)
        REG_CTRL:   rdata_nxt = {23'h0, ctrl_r};
        REG_RATE:   rdata_nxt = {2'h0, ext_per_r, 12'h0, rate_r};
        REG_SEQCNT: rdata_nxt = {22'h0, seqcnt_r};
        REG_SEL:    rdata_nxt = {22'h0, sel_r};
        REG_RANGE:  rdata_nxt = {6'h0, end_r, 6'h0, start_r};
        REG_STATUS: rdata_nxt = {5'h0, st_r, 6'h0, taken_r, fill_r[7:0]};
        REG_STAMP:  rdata_nxt = stamp_rd;
        REG_MAP:    rdata_nxt = {22'h0, map_r};
        REG_TIME:   rdata_nxt = time_r;
        default:    rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r    <= 9'h000;
      rate_r    <= 4'h0;
      ext_per_r <= 14'h0100;
      seqcnt_r  <= 10'h000;
      sel_r     <= '0;
      start_r   <= '0;
      end_r     <= '0;
      map_r     <= '0;
      time_r    <= 32'h0;
      wp_r      <= '0;
      fill_r    <= '0;
      taken_r   <= '0;
      inrec_r   <= 1'b0;
      dirty_r   <= 1'b0;
      st_r      <= ST_IDLE;
      rdata_r   <= 32'h0;
      ack_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      rate_r    <= rate_nxt;
      ext_per_r <= ext_per_nxt;
      seqcnt_r  <= seqcnt_nxt;
      sel_r     <= sel_nxt;
      start_r   <= start_nxt;
      end_r     <= end_nxt;
      map_r     <= map_nxt;
      time_r    <= time_nxt;
      wp_r      <= wp_nxt;
      fill_r    <= fill_nxt;
      taken_r   <= taken_nxt;
      inrec_r   <= inrec_nxt;
      dirty_r   <= dirty_nxt;
      st_r      <= st_nxt;
      rdata_r   <= rdata_nxt;
      ack_r     <= ack_nxt;
    end
  end

  // outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign mem_wr          = pt_valid;
  assign mem_data        = pt_data;
  assign rec_slot        = wp_r;
  assign sel_slot        = rd_idx;
  assign roll_en         = ctrl_r[CB_ROLL] & ~ctrl_r[CB_SEQ];
  assign highlight_hit   = ctrl_r[CB_ALL];

  a_roll_excl: assert property (@(posedge ref_clk) disable iff (rst)
    !(ctrl_r[CB_ROLL] && ctrl_r[CB_SEQ])) else $error("roll with sequence");
  a_seq_count: assert property (@(posedge ref_clk) disable iff (rst)
    (seqcnt_r == SEQ_INF) || (seqcnt_r >= SEQ_MIN && seqcnt_r <= SEQ_MAX))
    else $error("bad sequence count");
  a_partial_drop: assert property (@(posedge ref_clk) disable iff (rst)
    !running |=> $stable(fill_r) || $past(load_wr) || $past(wr_hit))
    else $error("history grew while stopped");
  a_sel_lock: assert property (@(posedge ref_clk) disable iff (rst)
    running && $past(running) |-> $stable(sel_r)) else $error("selection moved while running");
  a_range_order: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(start_r) |-> start_r <= sel_r && end_r >= sel_r) else $error("range order broken");
  a_ring_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (commit || load_wr) && wp_r == HIST_AW'(HIST_DEPTH - 1) |=> wp_r == '0)
    else $error("ring did not wrap");
  a_fill_cap: assert property (@(posedge ref_clk) disable iff (rst)
    fill_r <= HIST_AW'(HIST_DEPTH)) else $error("fill above depth");
  a_recall_avg: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_r[CB_RECALL] |-> !ctrl_r[CB_AVG] && !ctrl_r[CB_ACCUM]) else $error("recall under averaging");
endmodule
`default_nettype wire

//--- dv/was_dig_model.sv
// digitiser model: held 10 MS/s samples and triggered records
`timescale 1ns/1ps
`default_nettype none
module was_dig_model (
  input  wire logic                 ref_clk,
  input  wire logic                 rec_req,
  output logic [was_pkg::SMP_W-1:0] smp_in = 16'h0100,
  output logic                      trig_in = 1'b0,
  output logic                      rec_end = 1'b0
);
  import was_pkg::*;
  int unsigned ph = 0;
  int unsigned rc = 0;
  // each level held one sample period, two levels alternating
  always @(posedge ref_clk) begin
    ph <= (ph == SAMPLE_DIV - 1) ? 0 : ph + 1;
    if (ph == SAMPLE_DIV - 1) smp_in <= (smp_in === 16'h0100) ? 16'h0300 : 16'h0100;
    // record: trigger pulse, read-in complete 39 cycles later
    rc <= rec_req ? 1 : (rc != 0 && rc < 44) ? rc + 1 : 0;
    trig_in <= (rc >= 1 && rc <= 3);
    rec_end <= (rc >= 40 && rc <= 43);
  end
endmodule
`default_nettype wire

//--- dv/tb_was_top.sv
// testbench for the acquisition store control
`timescale 1ns/1ps
`default_nettype none
module tb_was_top;
  import was_pkg::*;
  typedef struct {was_rate_t rate; logic mavg; int cnt; logic avg;} was_row_t;
  localparam logic [31:0] K_RUN = 32'h1 << CB_RUN;
  localparam logic [31:0] K_SEQ = 32'h1 << CB_SEQ;
  localparam logic [31:0] K_MAVG = 32'h1 << CB_MAVG;
  localparam logic [31:0] K_ROLL = 32'h1 << CB_ROLL;
  localparam logic [31:0] K_ALL = 32'h1 << CB_ALL;
  localparam logic [31:0] K_AVG = 32'h1 << CB_AVG;
  localparam logic [31:0] K_RECALL = 32'h1 << CB_RECALL;
  logic                 ref_clk, rst, rec_req, avs_read, avs_write;
  logic [5:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, q;
  logic                 avs_waitrequest, mem_wr, roll_en, highlight_hit, trig_in, rec_end;
  logic [SMP_W-1:0]     smp_in, mem_data;
  logic [HIST_AW-1:0]   rec_slot, sel_slot, r0;
  int                   fail_count = 0;
  int                   n_compared = 0;
  int                   i;
  // normal and box-average rows: rate, mode, points per 4000 cycles
  was_row_t rows [7] = '{'{RATE_10M, 1'b0, 400, 1'b0}, '{RATE_5M, 1'b0, 200, 1'b0},
    '{RATE_1M, 1'b0, 40, 1'b0}, '{RATE_5M, 1'b1, 200, 1'b1}, '{RATE_2M, 1'b1, 80, 1'b1},
    '{RATE_500K, 1'b1, 20, 1'b1}, '{RATE_100K, 1'b1, 4, 1'b1}};
  logic [31:0] sq_w [5] = '{32'h1, 32'h2, 32'h3E9, 32'h3E8, 32'h0};
  logic [31:0] sq_e [5] = '{32'h0, 32'h2, 32'h2, 32'h3E8, 32'h0};

  was_top i_was_top (.ref_clk(ref_clk), .rst(rst), .smp_in(smp_in), .trig_in(trig_in),
    .rec_end(rec_end), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_wr(mem_wr), .mem_data(mem_data), .rec_slot(rec_slot), .sel_slot(sel_slot),
    .roll_en(roll_en), .highlight_hit(highlight_hit));
  was_dig_model i_was_dig_model (.ref_clk(ref_clk), .rec_req(rec_req), .smp_in(smp_in),
    .trig_in(trig_in), .rec_end(rec_end));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // points written and their values over a fixed span
  task automatic measure(input was_row_t rw);
    int n;
    int bad;
    n = 0;
    bad = 0;
    wr(REG_CTRL, 32'h0);
    wr(REG_RATE, {28'h0, rw.rate});
    wr(REG_CTRL, K_RUN | (rw.mavg ? K_MAVG : 32'h0));
    repeat (400) @(posedge ref_clk);
    repeat (4000) begin
      @(posedge ref_clk);
      if (mem_wr === 1'b1) begin
        n++;
        if (rw.avg ? mem_data !== 16'h0200 : !(mem_data === 16'h0100 || mem_data === 16'h0300)) bad++;
      end
    end
    chk("mem_data", 32'h0, bad);
    chk("mem_wr count", rw.cnt, (n == rw.cnt + 1 || n + 1 == rw.cnt) ? rw.cnt : n);
  endtask

  task automatic record();
    rec_req <= 1'b1;
    @(posedge ref_clk);
    rec_req <= 1'b0;
    repeat (60) @(posedge ref_clk);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (80000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    rec_req = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("reset outputs", 32'h0, {mem_wr, rec_slot, roll_en, highlight_hit});
    chk("reset sel_slot", HIST_DEPTH - 1, sel_slot);
    $display("test reset done");
    // sequence count settings, bad values ignored
    for (i = 0; i < 5; i++) begin
      wr(REG_SEQCNT, sq_w[i]);
      bus(1'b0, REG_SEQCNT, 32'h0, q);
      chk("seq count", sq_e[i], q);
    end
    $display("test seq count done");
    for (i = 0; i < 7; i++) measure(rows[i]);
    $display("test sampling done");
    // sequential store waits for real triggers
    wr(REG_CTRL, 32'h0);
    wr(REG_SEQCNT, 32'h2);
    wr(REG_CTRL, K_RUN | K_SEQ | K_ROLL);
    chk("roll_en seq", 32'h0, {31'h0, roll_en});
    r0 = rec_slot;
    repeat (300) @(posedge ref_clk);
    chk("rec_slot idle", r0, rec_slot);
    record();
    record();
    chk("rec_slot two", r0 + 10'h2, rec_slot);
    wr(REG_CTRL, K_RUN | K_ROLL);
    chk("roll_en", 32'h1, {31'h0, roll_en});
    wr(REG_CTRL, K_RUN | K_ALL);
    chk("highlight", 32'h1, {31'h0, highlight_hit});
    $display("test sequence done");
    // stop during read-in drops the partial record
    wr(REG_CTRL, K_RUN);
    r0 = rec_slot;
    rec_req <= 1'b1;
    @(posedge ref_clk);
    rec_req <= 1'b0;
    wr(REG_CTRL, 32'h0);
    repeat (60) @(posedge ref_clk);
    chk("rec_slot partial", r0, rec_slot);
    // loaded records wrap the ring, newest load becomes index 0
    for (i = 0; i < HIST_DEPTH; i++) wr(REG_LOAD, {i[23:0], 8'hFF});
    chk("rec_slot wrap", r0, rec_slot);
    chk("sel_slot newest", 32'h1, sel_slot);
    bus(1'b0, REG_STAMP, 32'h0, q);
    chk("load stamp", {24'd999, 8'h00}, q);
    // selection taken when stopped, locked while running
    wr(REG_SEL, 32'h1);
    bus(1'b0, REG_SEL, 32'h0, q);
    chk("sel stopped", 32'h1, q);
    // range order, all-display selection bound and map page
    wr(REG_RANGE, 32'h00050000);
    wr(REG_RANGE, 32'h00050002);
    bus(1'b0, REG_RANGE, 32'h0, q);
    chk("range", 32'h00050000, q);
    wr(REG_CTRL, K_ALL);
    wr(REG_SEL, 32'h6);
    bus(1'b0, REG_SEL, 32'h0, q);
    chk("sel all", 32'h1, q);
    wr(REG_MAP, 32'h9);
    wr(REG_MAP, 32'hA);
    bus(1'b0, REG_MAP, 32'h0, q);
    chk("map page", 32'h9, q);
    wr(REG_CTRL, K_RUN);
    wr(REG_SEL, 32'h0);
    bus(1'b0, REG_SEL, 32'h0, q);
    chk("sel running", 32'h1, q);
    // recall halts acquisition and is refused under averaging
    wr(REG_CTRL, K_RUN | K_RECALL);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk("recall halts", {29'h0, ST_IDLE}, {29'h0, q[26:24]});
    wr(REG_CTRL, K_RECALL | K_AVG);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk("recall refused", K_AVG, q);
    $display("test history done");
    end_sim();
  end
endmodule
`default_nettype wire
